// ==== rtl/dbgp_regs.svh ====
// How it works
// - status bit 5 is high while any flash read, write or erase runs
// - status bit 3 is one when a halt command from the port stopped the cpu
// - status bit 2 is one when the pc hit the last breakpoint address
// - status bit 1 is one when a software break instruction stopped the cpu
// - status bit 0 is one only while the cpu runs freely
// - all three halt cause flags clear when free running starts
// - port is open or closed; open must come before anything else
// - while closed, every frame except open is ignored
// - init_fuse_override_cmd operand becomes a fuse word override until the next full reset
// - debug reset keeps clock selection and halts like the halt command
// - full reset resets chip, drops override, closes port, runs from vector
// - answer frame is done bit, echoed opcode, sixteen bit return value
// - opcode 0001000 loads and returns the pointer upper word
// - opcode 0001001 loads and returns the pointer lower word
// - opcode 0011001 raises debug interrupt only if the cpu was running, stops watchdog, returns status and w
// - opcode 0010011 erases when halted and not busy; config too if bit 16, unprotected, blank
// - erase_everything_cmd lasts about 200 ms with the busy flag held
// - opcode 0111110 closes the port and returns the status word
// - first answer after opening is 0x800000
// - when halted the cpu stalls on no-ops without moving the pc
`ifndef DBGP_REGS_SVH
`define DBGP_REGS_SVH
// ****************************************
// status word fields
// ****************************************
`define DBGP_ST_RUN 0
`define DBGP_ST_SBRK 1
`define DBGP_ST_HBRK 2
`define DBGP_ST_CBRK 3
`define DBGP_ST_BUSY 5
// ****************************************
// frame layout and opcodes
// ****************************************
`define DBGP_LAST_BIT 5'h17
`define DBGP_ACK_FIRST 24'h800000
`define DBGP_PTR_CFG_BIT 16
`define DBGP_OP_LOAD_POINTER_UPPER_CMD 7'h08
`define DBGP_OP_LOAD_POINTER_LOWER_CMD 7'h09
`define DBGP_OP_BREAK 7'h19
`define DBGP_OP_ERASE 7'h13
`define DBGP_OP_CLOSE 7'h3e
`define DBGP_OP_DBG_RESET 7'h07
`define DBGP_OP_OPEN 7'h7a
`define DBGP_OP_INIT 7'h70
`define DBGP_OP_RESET_ALL 7'h0f
`define DBGP_OP_SET_BREAKPOINT_CMD 7'h18
`define DBGP_OP_RUN 7'h1b
// ****************************************
// timing
// ****************************************
`define DBGP_ERASE_MS 200
`define DBGP_CLK_KHZ 20000
`endif

// ==== rtl/dbgp_pkg.sv ====
package dbgp_pkg;
  // cpu execution mode, gray along run-halt
  typedef enum logic [1:0] {
    DBGP_RUN = 2'h0,
    DBGP_HALT = 2'h1
  } dbgp_mode_t;
  typedef logic [23:0] dbgp_frame_t;
endpackage : dbgp_pkg

// ==== rtl/dbgp_port.sv ====
`timescale 1ns/100ps
`include "dbgp_regs.svh"
module dbgp_port #(
  parameter int ERASE_CYCLES = `DBGP_ERASE_MS * `DBGP_CLK_KHZ
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic link_serial_clock_in,
  input wire logic link_select_n_in,
  input wire logic link_data_in,
  output logic link_data_out,
  input wire logic [15:0] cpu_pc_in,
  input wire logic [7:0] cpu_status_in,
  input wire logic [7:0] cpu_w_in,
  input wire logic cpu_sw_break_in,
  input wire logic flash_busy_in,
  input wire logic flash_blank_in,
  input wire logic code_protect_n_in,
  output logic [15:0] debug_port_status_out,
  output logic cpu_halt_out,
  output logic debug_irq_out,
  output logic watchdog_suspend_out,
  output logic [15:0] fuse_override_out,
  output logic fuse_override_en_out,
  output logic chip_reset_out,
  output logic cpu_reset_out,
  output logic erase_start_out,
  output logic erase_config_out,
  output logic port_open_out,
  output logic [31:0] addr_pointer_out
);
  import dbgp_pkg::*;

  localparam int CNT_W = $clog2(ERASE_CYCLES + 1);

  // elaboration check on the erase length
  if (ERASE_CYCLES < 1) begin : g_chk
    $error("ERASE_CYCLES must be at least one");
  end

  // ****************************************
  // link synchronisers
  // ****************************************
  logic sck_m, sck_s, sck_d;
  logic sel_m, sel_s, sel_d;
  logic dat_m, dat_s;

  // two flops per pin, third only for edges
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      sel_m <= 1'b1;
      sel_s <= 1'b1;
      sel_d <= 1'b1;
      dat_m <= 1'b0;
      dat_s <= 1'b0;
    end else begin
      sck_m <= link_serial_clock_in;
      sck_s <= sck_m;
      sck_d <= sck_s;
      sel_m <= link_select_n_in;
      sel_s <= sel_m;
      sel_d <= sel_s;
      dat_m <= link_data_in;
      dat_s <= dat_m;
    end
  end

  // edge and select decode
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire selected = ~sel_s;
  wire sel_start = ~sel_s & sel_d;

  // ****************************************
  // frame shifter
  // ****************************************
  logic [22:0] rx;
  logic [23:0] tx;
  logic [4:0] bit_cnt;
  dbgp_frame_t ack_word;
  logic port_open;
  dbgp_mode_t mode;
  dbgp_mode_t next_mode;

  wire frame_done = selected & sck_rise & (bit_cnt == `DBGP_LAST_BIT);
  wire [23:0] frame_word = {rx, dat_s};
  wire [6:0] op = frame_word[22:16];
  wire [15:0] operand = frame_word[15:0];

  // receive on rising, send on falling link clock
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rx <= 23'h0;
      tx <= 24'h0;
      bit_cnt <= 5'h0;
      link_data_out <= 1'b0;
    end else if (!selected) begin
      bit_cnt <= 5'h0;
      link_data_out <= 1'b0;
    end else if (sel_start) begin
      tx <= {ack_word[22:0], 1'b0};
      link_data_out <= ack_word[23];
      bit_cnt <= 5'h0;
    end else if (sck_rise) begin
      rx <= frame_word[22:0];
      bit_cnt <= frame_done ? 5'h0 : bit_cnt + 5'h01;
    end else if (sck_fall) begin
      link_data_out <= tx[23];
      tx <= {tx[22:0], 1'b0};
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  // zero msb required
  wire frame_ok = frame_done & ~frame_word[23];
  wire cmd_open = frame_ok & (op == `DBGP_OP_OPEN);
  wire act = frame_ok & port_open;
  wire running = (mode == DBGP_RUN);
  wire halted = (mode == DBGP_HALT);
  wire is_hi = act & (op == `DBGP_OP_LOAD_POINTER_UPPER_CMD);
  wire is_lo = act & (op == `DBGP_OP_LOAD_POINTER_LOWER_CMD);
  wire is_break = act & (op == `DBGP_OP_BREAK);
  wire is_erase = act & (op == `DBGP_OP_ERASE);
  wire is_close = act & (op == `DBGP_OP_CLOSE);
  wire is_dreset = act & (op == `DBGP_OP_DBG_RESET);
  wire is_init = act & (op == `DBGP_OP_INIT);
  wire is_rall = act & (op == `DBGP_OP_RESET_ALL);
  wire is_bkpt = act & (op == `DBGP_OP_SET_BREAKPOINT_CMD);
  wire is_run = act & (op == `DBGP_OP_RUN);

  logic [CNT_W-1:0] erase_cnt;
  logic [31:0] addr_ptr;
  logic [15:0] bkpt_addr;
  logic bkpt_en;
  logic flag_cmd, flag_bkpt, flag_sw;
  logic [15:0] next_status;

  // busy from erase timer or flash
  wire busy = (erase_cnt != '0) | flash_busy_in;
  wire do_break = is_break | is_dreset | is_init;
  wire bkpt_hit = running & bkpt_en & (cpu_pc_in == bkpt_addr);
  wire sw_hit = running & cpu_sw_break_in;
  wire run_entry = (next_mode == DBGP_RUN) & halted;
  wire erase_go = is_erase & halted & ~busy;
  wire erase_cfg = addr_ptr[`DBGP_PTR_CFG_BIT] & code_protect_n_in & flash_blank_in;
  wire ret_cpu = is_break | is_erase | is_dreset | is_run;

  wire [15:0] ret = (is_hi | is_lo) ? operand :
                    is_close ? next_status :
                    ret_cpu ? {cpu_status_in, cpu_w_in} : 16'h0;

  // ****************************************
  // cpu mode machine
  // ****************************************
  // full reset or run command runs, any break cause halts, mode holds otherwise
  always_comb begin
    next_mode = mode;
    case (mode)
      DBGP_RUN: begin
        if (is_rall) begin
          next_mode = DBGP_RUN;
        end else if (do_break | bkpt_hit | sw_hit) begin
          next_mode = DBGP_HALT;
        end
      end
      DBGP_HALT: begin
        if (is_rall | is_run) begin
          next_mode = DBGP_RUN;
        end
      end
      default: next_mode = DBGP_HALT;
    endcase
  end

  // status word build
  always_comb begin
    next_status = 16'h0;
    next_status[`DBGP_ST_BUSY] = busy;
    next_status[`DBGP_ST_CBRK] = flag_cmd;
    next_status[`DBGP_ST_HBRK] = flag_bkpt;
    next_status[`DBGP_ST_SBRK] = flag_sw;
    next_status[`DBGP_ST_RUN] = running;
  end

  // mode, port state and flags
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode <= DBGP_RUN;
      port_open <= 1'b0;
      flag_cmd <= 1'b0;
      flag_bkpt <= 1'b0;
      flag_sw <= 1'b0;
    end else begin
      mode <= next_mode;
      if (is_close | is_rall) begin
        port_open <= 1'b0;
      end else if (cmd_open) begin
        port_open <= 1'b1;
      end
      if (run_entry | is_rall) begin
        flag_cmd <= 1'b0;
        flag_bkpt <= 1'b0;
        flag_sw <= 1'b0;
      end else begin
        flag_cmd <= flag_cmd | do_break;
        flag_bkpt <= flag_bkpt | bkpt_hit;
        flag_sw <= flag_sw | sw_hit;
      end
    end
  end

  // pointer, breakpoint, override, ack
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      addr_ptr <= 32'h0;
      bkpt_addr <= 16'h0;
      bkpt_en <= 1'b0;
      fuse_override_out <= 16'h0;
      fuse_override_en_out <= 1'b0;
      ack_word <= 24'h0;
    end else begin
      if (is_hi) begin
        addr_ptr[31:16] <= operand;
      end
      if (is_lo) begin
        addr_ptr[15:0] <= operand;
      end
      if (is_bkpt) begin
        bkpt_addr <= operand;
        bkpt_en <= 1'b1;
      end else if (is_rall) begin
        bkpt_en <= 1'b0;
      end
      if (is_init) begin
        fuse_override_out <= operand;
        fuse_override_en_out <= 1'b1;
      end else if (is_rall) begin
        fuse_override_en_out <= 1'b0;
      end
      if (cmd_open & ~port_open) begin
        ack_word <= `DBGP_ACK_FIRST;
      end else if (act) begin
        ack_word <= {1'b1, op, ret};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      erase_cnt <= '0;
    end else if (erase_go) begin
      erase_cnt <= CNT_W'(ERASE_CYCLES);
    end else if (erase_cnt != '0) begin
      erase_cnt <= erase_cnt - CNT_W'(1);
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      debug_port_status_out <= 16'h0;
      cpu_halt_out <= 1'b0;
      debug_irq_out <= 1'b0;
      watchdog_suspend_out <= 1'b0;
      chip_reset_out <= 1'b0;
      cpu_reset_out <= 1'b0;
      erase_start_out <= 1'b0;
      erase_config_out <= 1'b0;
      port_open_out <= 1'b0;
      addr_pointer_out <= 32'h0;
    end else begin
      debug_port_status_out <= next_status;
      cpu_halt_out <= (next_mode == DBGP_HALT);
      debug_irq_out <= do_break & running;
      watchdog_suspend_out <= (next_mode == DBGP_HALT) & port_open;
      chip_reset_out <= is_rall;
      cpu_reset_out <= is_dreset;
      erase_start_out <= erase_go;
      erase_config_out <= erase_go & erase_cfg;
      port_open_out <= port_open;
      addr_pointer_out <= addr_ptr;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // status register trails the timer by one clock
  erase_busy_a: assert property (erase_start_out |=> debug_port_status_out[`DBGP_ST_BUSY])
    else $error("busy low after erase start");
  busy_hold_a: assert property (erase_go |=> busy [*8])
    else $error("busy dropped early");
  run_bit_a: assert property (halted |=> !debug_port_status_out[0])
    else $error("run bit while halted");
  cmd_flag_a: assert property (do_break & !is_rall |=> ##1 debug_port_status_out[3])
    else $error("command halt flag missing");
  bkpt_flag_a: assert property (bkpt_hit & !is_rall |=> halted ##0 flag_bkpt)
    else $error("breakpoint flag missing");
  sw_flag_a: assert property (sw_hit & !is_rall |=> ##1 debug_port_status_out[1])
    else $error("software break flag missing");
  flag_clear_a: assert property (run_entry |=> !(flag_cmd | flag_bkpt | flag_sw))
    else $error("halt flags kept on run");
  closed_ignore_a: assert property (!port_open & frame_done |=> $stable(addr_ptr))
    else $error("closed port acted");
  first_ack_a: assert property (cmd_open & !port_open |=> ack_word == `DBGP_ACK_FIRST)
    else $error("first answer wrong");
  // reset pulse, closed port and run mode all show one clock later
  reset_all_a: assert property (is_rall |=> !port_open && running && chip_reset_out)
    else $error("full reset incomplete");
  reserved_zero_a: assert property (debug_port_status_out[15:6] == 10'h0 &&
                                    !debug_port_status_out[4])
    else $error("reserved status bits set");
endmodule : dbgp_port

// ==== testbench/dbgp_host.sv ====
`timescale 1ns/100ps
// ****************************************
// debugger at the far end of the link
// ****************************************
module dbgp_host (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic sel_n_out,
  output logic mosi_out
);
  import dbgp_pkg::*;
  // link rests with clock low and nothing selected
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one frame, four system clocks per link half period
  // frame layout built
  task automatic send(input logic [6:0] op, input logic [15:0] arg,
                      output dbgp_frame_t ans);
    dbgp_frame_t cmd;
    cmd = {1'b0, op, arg};
    repeat (8) @(negedge clk_in);
    sel_n_out = 1'b0;
    repeat (8) @(negedge clk_in);
    for (int i = 23; i >= 0; i--) begin
      mosi_out = cmd[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      ans[i] = miso_in; // answer bit still held just before the fall
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    sel_n_out = 1'b1;
    mosi_out = ~mosi_out; // released line shows no stale value
  endtask : send
endmodule : dbgp_host

// ==== testbench/debug_program_port_commands_bench.sv ====
`timescale 1ns/100ps
`include "dbgp_regs.svh"
module debug_program_port_commands_bench;
  import dbgp_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sclk, sel_n, mosi, miso;
  logic [15:0] pc = 16'h0000;
  logic brk = 1'b0;
  logic flash_busy_flag = 1'b0;
  logic blank = 1'b1;
  logic cpn = 1'b1;
  logic [15:0] status, fuse;
  logic halt, irq, wdog, fuse_en, chip_rst, cpu_rst, er_go, er_cfg, is_open;
  logic [31:0] ptr;
  int miscompares = 0;
  int checks_done = 0;
  int n_er = 0;
  int n_cfg = 0;
  int n_chip = 0;
  int n_cpu = 0;
  int n_irq = 0;
  dbgp_frame_t ans;
  // ****************************************
  // clock, parts and pulse counters
  // ****************************************
  always #25 clk_in = ~clk_in;
  dbgp_host host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .sel_n_out(sel_n),
                  .mosi_out(mosi));
  dbgp_port #(.ERASE_CYCLES(20)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .link_serial_clock_in(sclk), .link_select_n_in(sel_n), .link_data_in(mosi),
    .link_data_out(miso), .cpu_pc_in(pc), .cpu_status_in(8'ha5), .cpu_w_in(8'h3c),
    .cpu_sw_break_in(brk), .flash_busy_in(flash_busy_flag), .flash_blank_in(blank),
    .code_protect_n_in(cpn), .debug_port_status_out(status), .cpu_halt_out(halt),
    .debug_irq_out(irq), .watchdog_suspend_out(wdog), .fuse_override_out(fuse),
    .fuse_override_en_out(fuse_en), .chip_reset_out(chip_rst), .cpu_reset_out(cpu_rst),
    .erase_start_out(er_go), .erase_config_out(er_cfg), .port_open_out(is_open),
    .addr_pointer_out(ptr));
  // count the single-cycle pulses
  always @(posedge clk_in) begin
    if (er_go === 1'b1) n_er++;
    if (er_cfg === 1'b1) n_cfg++;
    if (chip_rst === 1'b1) n_chip++;
    if (cpu_rst === 1'b1) n_cpu++;
    if (irq === 1'b1) n_irq++;
  end
  // ****************************************
  // compare and helper tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_st(input logic [15:0] exp);
    chk({16'h0, status}, {16'h0, exp}, "status");
  endtask : chk_st
  task automatic go(input logic [6:0] op, input logic [15:0] arg);
    host.send(op, arg, ans);
    repeat (4) @(negedge clk_in);
  endtask : go
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_closed();
    chk_st(16'h0001);
    go(`DBGP_OP_LOAD_POINTER_UPPER_CMD, 16'h00ff);
    chk(ptr, 32'h0, "closed pointer");
    chk({31'h0, is_open}, 32'h0, "open flag");
  endtask : t_closed
  task automatic t_open_ptr();
    go(`DBGP_OP_OPEN, 16'h0000);
    chk({31'h0, is_open}, 32'h1, "open flag");
    go(`DBGP_OP_LOAD_POINTER_UPPER_CMD, 16'h0001);
    chk({8'h0, ans}, 32'h800000, "first answer");
    go(`DBGP_OP_LOAD_POINTER_LOWER_CMD, 16'h1234);
    chk({8'h0, ans}, 32'h880001, "upper answer");
    chk(ptr, 32'h00011234, "pointer");
  endtask : t_open_ptr
  task automatic t_break();
    go(`DBGP_OP_BREAK, 16'h0000);
    chk({8'h0, ans}, 32'h891234, "lower answer");
    chk_st(16'h0008);
    chk({30'h0, halt, wdog}, 32'h3, "halt and watchdog");
    chk(n_irq, 32'h1, "debug irq");
    go(`DBGP_OP_LOAD_POINTER_UPPER_CMD, 16'h0001);
    chk({8'h0, ans}, 32'h99a53c, "break answer");
  endtask : t_break
  task automatic t_erase();
    go(`DBGP_OP_ERASE, 16'h0000);
    chk({n_er[15:0], n_cfg[15:0]}, 32'h00010001, "erase with config");
    chk_st(16'h0028);
    repeat (30) @(negedge clk_in);
    chk_st(16'h0008);
    flash_busy_flag = 1'b1;
    repeat (3) @(negedge clk_in);
    chk_st(16'h0028);
    flash_busy_flag = 1'b0;
    blank = 1'b0;
    go(`DBGP_OP_ERASE, 16'h0000);
    repeat (30) @(negedge clk_in);
    chk({n_er[15:0], n_cfg[15:0]}, 32'h00020001, "erase keeps config");
  endtask : t_erase
  task automatic t_causes();
    go(`DBGP_OP_RUN, 16'h0000);
    chk_st(16'h0001);
    go(`DBGP_OP_ERASE, 16'h0000);
    chk(n_er, 32'h2, "no erase while running");
    brk = 1'b1;
    @(negedge clk_in);
    brk = 1'b0;
    repeat (4) @(negedge clk_in);
    chk_st(16'h0002);
    go(`DBGP_OP_SET_BREAKPOINT_CMD, 16'h0040);
    go(`DBGP_OP_RUN, 16'h0000);
    chk_st(16'h0001);
    pc = 16'h0040;
    repeat (4) @(negedge clk_in);
    chk_st(16'h0004);
    chk({31'h0, halt}, 32'h1, "breakpoint halt");
    pc = 16'h0000;
  endtask : t_causes
  task automatic t_resets();
    go(`DBGP_OP_RUN, 16'h0000);
    go(`DBGP_OP_DBG_RESET, 16'h0000);
    chk(n_cpu, 32'h1, "cpu reset pulse");
    chk_st(16'h0008);
    go(`DBGP_OP_INIT, 16'hbeef);
    chk({15'h0, fuse_en, fuse}, 32'h1beef, "fuse override");
    go(`DBGP_OP_CLOSE, 16'h0000);
    chk({31'h0, is_open}, 32'h0, "closed");
    go(`DBGP_OP_LOAD_POINTER_LOWER_CMD, 16'h5555);
    chk({8'h0, ans}, 32'hbe0008, "close answer");
    chk(ptr, 32'h00011234, "pointer kept");
    go(`DBGP_OP_OPEN, 16'h0000);
    go(`DBGP_OP_RESET_ALL, 16'h0000);
    chk(n_chip, 32'h1, "chip reset pulse");
    chk({30'h0, is_open, fuse_en}, 32'h0, "closed, no override");
    chk_st(16'h0001);
  endtask : t_resets
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial begin
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_closed();
    t_open_ptr();
    t_break();
    t_erase();
    t_causes();
    t_resets();
    print_verdict();
  end
  // cut a hung run short
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    $display("ERROR %0t run too long", $time);
    print_verdict();
  end
endmodule : debug_program_port_commands_bench
